// file: sps_pkg.sv
// sps_pkg: constants and carrier types of the sequencer.
// assumes a single 200 MHz clock; all analog comparators are digitised outside.
package sps_pkg;

   localparam int unsigned SPS_CLK_HZ = 200_000_000;

   // intervals in their own units
   localparam int unsigned SPS_LINE_DET_MS = 40;
   localparam int unsigned SPS_DISCH_MS = 40;
   localparam int unsigned SPS_LINE_GOOD_US = 100;
   localparam int unsigned SPS_LINE_LOW_MS = 50;
   localparam int unsigned SPS_EXT_LOW_MS = 32;
   localparam int unsigned SPS_UV_BLANK_MS = 4;
   localparam int unsigned SPS_SAMPLE_NS = 1000;
   localparam int unsigned SPS_PRE_EDGE_NS = 100;

   // cycle counts from the clock rate
   localparam int unsigned SPS_LINE_DET_CYC = SPS_LINE_DET_MS * (SPS_CLK_HZ / 1000);
   localparam int unsigned SPS_DISCH_CYC = SPS_DISCH_MS * (SPS_CLK_HZ / 1000);
   localparam int unsigned SPS_LINE_GOOD_CYC = SPS_LINE_GOOD_US * (SPS_CLK_HZ / 1_000_000);
   localparam int unsigned SPS_LINE_LOW_CYC = SPS_LINE_LOW_MS * (SPS_CLK_HZ / 1000);
   localparam int unsigned SPS_EXT_LOW_CYC = SPS_EXT_LOW_MS * (SPS_CLK_HZ / 1000);
   localparam int unsigned SPS_UV_BLANK_CYC = SPS_UV_BLANK_MS * (SPS_CLK_HZ / 1000);
   localparam int unsigned SPS_SAMPLE_CYC = (SPS_SAMPLE_NS * (SPS_CLK_HZ / 1_000_000)) / 1000;
   localparam int unsigned SPS_PRE_EDGE_CYC = (SPS_PRE_EDGE_NS * (SPS_CLK_HZ / 1_000_000)) / 1000;

   // consecutive cycles for the counted faults
   localparam int unsigned SPS_FAULT_CYCLES = 7;

   // APB register byte addresses
   localparam logic [7:0] SPS_ADDR_STATUS = 8'h00;
   localparam logic [7:0] SPS_ADDR_INT_STAT = 8'h04;
   localparam logic [7:0] SPS_ADDR_INT_MASK = 8'h08;
   localparam logic [7:0] SPS_ADDR_CTRL = 8'h0C;

   // event bit positions in the interrupt status/mask registers
   localparam int unsigned SPS_EV_OVP = 0;
   localparam int unsigned SPS_EV_UVP = 1;
   localparam int unsigned SPS_EV_EXT_HI = 2;
   localparam int unsigned SPS_EV_EXT_LO = 3;
   localparam int unsigned SPS_EV_LINE_LOW = 4;
   localparam int unsigned SPS_EV_DISCH = 5;
   localparam int unsigned SPS_EV_W = 6;

   // control register fields
   localparam int unsigned SPS_CTRL_UVP_EN = 0;
   localparam int unsigned SPS_CTRL_EXT_EN = 1;
   localparam logic [1:0] SPS_CTRL_RESET = 2'h3;

   typedef enum logic [1:0] {
      SPS_CHG_OFF = 2'b00,
      SPS_CHG_LOW = 2'b01,
      SPS_CHG_HIGH = 2'b10,
      SPS_CHG_FAULT = 2'b11
   } sps_charge_t;

   typedef enum logic [1:0] {
      SPS_PWR_CHARGE = 2'b00,
      SPS_PWR_RUN = 2'b01,
      SPS_PWR_LATCH = 2'b10
   } sps_power_t;

   // digitised comparator inputs
   typedef struct packed {
      logic supply_above_6v;
      logic supply_at_start;
      logic supply_below_uvlo;
      logic line_above_good;
      logic line_below_low;
      logic line_pin_below_10v;
      logic line_cross;
      logic demag_over;
      logic demag_under;
      logic ext_above_high;
      logic ext_below_low;
      logic gate_in;
   } sps_cmp_t;

   localparam int unsigned SPS_CMP_W = $bits(sps_cmp_t);

endpackage

// file: sps_sequencer.sv
// sps_sequencer: startup charger select, line capacitor discharge, line
// qualification and switching-cycle fault counting, with an APB window.
// assumes comparator inputs come straight from analog pins (synchronised here).
//
// Summary of operation
// [R1] low charge below 6V, high above
// [R2] charger off once start threshold reached
// [R3] after fault, charge only below undervoltage level
// [R4] start 40ms line-detect timer at plug-in
// [R5] every line crossing restarts the detect timer
// [R6] timer expiry: 1.7mA sink for 40ms
// [R7] alternate detect/discharge until pin under 10V
// [R8] gate on after 100us line good plus start
// [R9] 50ms line low stops gate until requalified
// [R10] sample demag pin after gate falling edge
// [R11] seven consecutive output faults latch shutdown
// [R12] undervoltage fault blanked at startup
// [R13] seven consecutive external-high samples latch shutdown
// [R14] external-low sample 100ns before gate fall
// [R15] external-low held 32ms latches shutdown
// [R16] external faults hold gate off until undervoltage
// [R17] source 100uA from control pin always
// [R18] synchronised comparators, counts from one clock
`timescale 1ns/1ps
module sps_sequencer
   import sps_pkg::*;
#(
   parameter int unsigned LINE_DET_CYC = SPS_LINE_DET_CYC,
   parameter int unsigned DISCH_CYC = SPS_DISCH_CYC,
   parameter int unsigned LINE_LOW_CYC = SPS_LINE_LOW_CYC,
   parameter int unsigned EXT_LOW_CYC = SPS_EXT_LOW_CYC,
   parameter int unsigned UV_BLANK_CYC = SPS_UV_BLANK_CYC,
   parameter int unsigned LINE_GOOD_CYC = SPS_LINE_GOOD_CYC,
   parameter int unsigned FAULT_CYCLES = SPS_FAULT_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire sps_cmp_t cmp_in,
   input wire logic gate_request,
   output logic gate_drive,
   output sps_charge_t charge_sel,
   output logic discharge_sink_en,
   output logic ext_source_en,
   output logic irq
);

   localparam int unsigned CW = 32;

   ////////////////////////////////////////////////////////////////////////////
   // synchronisers
   // [R18] two-stage sync
   sps_cmp_t sync1_reg;
   sps_cmp_t cmp;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= '0;
         cmp <= '0;
      end else begin
         sync1_reg <= cmp_in;
         cmp <= sync1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers and state
   sps_power_t pwr_reg;
   logic [1:0] ctrl_reg;
   logic [SPS_EV_W-1:0] int_stat_reg;
   logic [SPS_EV_W-1:0] int_mask_reg;
   logic [SPS_EV_W-1:0] ev;
   logic line_ok_reg;
   logic [CW-1:0] good_cnt_reg;
   logic [CW-1:0] low_cnt_reg;
   logic [CW-1:0] xcap_cnt_reg;
   logic xcap_disch_reg;
   logic [CW-1:0] blank_cnt_reg;
   logic [CW-1:0] ext_low_cnt_reg;
   logic [CW-1:0] edge_cnt_reg;
   logic gate_prev_reg;
   logic [2:0] ovp_cnt_reg;
   logic [2:0] uvp_cnt_reg;
   logic [2:0] exh_cnt_reg;
   logic ext_low_smp_reg;
   logic [SPS_PRE_EDGE_CYC:0] ext_low_hist_reg;
   logic fault_trip;
   logic gate_fall;
   logic sample_now;
   logic cross_prev_reg;
   logic cross_edge;

   assign gate_fall = gate_prev_reg && !cmp.gate_in;
   // [R10] fixed sample delay
   assign sample_now = (edge_cnt_reg == CW'(SPS_SAMPLE_CYC));
   assign cross_edge = cmp.line_cross != cross_prev_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_prev_reg <= 1'b0;
         cross_prev_reg <= 1'b0;
      end else begin
         gate_prev_reg <= cmp.gate_in;
         cross_prev_reg <= cmp.line_cross;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power state machine and charger select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_reg <= SPS_PWR_CHARGE;
      end else begin
         case (pwr_reg)
            // [R2] start threshold ends charging
            SPS_PWR_CHARGE: if (cmp.supply_at_start) pwr_reg <= SPS_PWR_RUN;
            SPS_PWR_RUN: if (fault_trip) pwr_reg <= SPS_PWR_LATCH;
            // [R3] release only below undervoltage level
            SPS_PWR_LATCH: if (cmp.supply_below_uvlo) pwr_reg <= SPS_PWR_CHARGE;
            default: pwr_reg <= SPS_PWR_CHARGE;
         endcase
      end
   end

   // last charge follows a fault: reduced current
   logic after_fault_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         after_fault_reg <= 1'b0;
      end else if (pwr_reg == SPS_PWR_LATCH) begin
         after_fault_reg <= 1'b1;
      end else if (pwr_reg == SPS_PWR_RUN) begin
         after_fault_reg <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         charge_sel <= SPS_CHG_OFF;
      end else if (pwr_reg != SPS_PWR_CHARGE || cmp.supply_at_start) begin
         // [R2] charger fully off
         charge_sel <= SPS_CHG_OFF;
      end else if (after_fault_reg) begin
         // [R3] reduced fault current
         charge_sel <= SPS_CHG_FAULT;
      end else if (cmp.supply_above_6v) begin
         // [R1] high current above 6V
         charge_sel <= SPS_CHG_HIGH;
      end else begin
         charge_sel <= SPS_CHG_LOW;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // line capacitor discharge, independent of supply level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xcap_cnt_reg <= '0;
         xcap_disch_reg <= 1'b0;
      end else if (!xcap_disch_reg) begin
         if (cross_edge) begin
            // [R5] crossing restarts timer
            xcap_cnt_reg <= '0;
         end else if (xcap_cnt_reg >= CW'(LINE_DET_CYC - 1)) begin
            // [R6] expiry opens discharge
            xcap_cnt_reg <= '0;
            xcap_disch_reg <= !cmp.line_pin_below_10v;
         end else begin
            // [R4] detect timer runs
            xcap_cnt_reg <= xcap_cnt_reg + 1'b1;
         end
      end else begin
         // [R7] alternate until below 10V
         if (cmp.line_pin_below_10v || xcap_cnt_reg >= CW'(DISCH_CYC - 1)) begin
            xcap_cnt_reg <= '0;
            xcap_disch_reg <= 1'b0;
         end else begin
            xcap_cnt_reg <= xcap_cnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         discharge_sink_en <= 1'b0;
      end else begin
         // [R6] sink while discharging
         discharge_sink_en <= xcap_disch_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // line qualification
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         good_cnt_reg <= '0;
         low_cnt_reg <= '0;
         line_ok_reg <= 1'b0;
      end else begin
         good_cnt_reg <= cmp.line_above_good ? good_cnt_reg + 1'b1 : '0;
         low_cnt_reg <= cmp.line_below_low ? low_cnt_reg + 1'b1 : '0;
         if (!line_ok_reg && good_cnt_reg >= CW'(LINE_GOOD_CYC - 1)) begin
            // [R8] line good after filter
            line_ok_reg <= 1'b1;
         end else if (line_ok_reg && low_cnt_reg >= CW'(LINE_LOW_CYC - 1)) begin
            // [R9] line low after 50ms
            line_ok_reg <= 1'b0;
         end
         if (good_cnt_reg == '1) good_cnt_reg <= good_cnt_reg;
         if (low_cnt_reg == '1) low_cnt_reg <= low_cnt_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // switching-cycle fault counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_cnt_reg <= '1;
      end else if (gate_fall) begin
         edge_cnt_reg <= '0;
      end else if (edge_cnt_reg != '1) begin
         edge_cnt_reg <= edge_cnt_reg + 1'b1;
      end
   end

   // startup blanking counted from entry into run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blank_cnt_reg <= '0;
      end else if (pwr_reg != SPS_PWR_RUN) begin
         blank_cnt_reg <= '0;
      end else if (blank_cnt_reg < CW'(UV_BLANK_CYC)) begin
         blank_cnt_reg <= blank_cnt_reg + 1'b1;
      end
   end

   function automatic logic [2:0] cyc_count(input logic [2:0] cnt, input logic hit);
      cyc_count = hit ? ((cnt == 3'(FAULT_CYCLES)) ? cnt : cnt + 3'h1) : 3'h0;
   endfunction

   logic uv_blank;
   // [R12] ignore under-voltage during blank
   assign uv_blank = blank_cnt_reg < CW'(UV_BLANK_CYC);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovp_cnt_reg <= '0;
         uvp_cnt_reg <= '0;
         exh_cnt_reg <= '0;
      end else if (pwr_reg != SPS_PWR_RUN) begin
         ovp_cnt_reg <= '0;
         uvp_cnt_reg <= '0;
         exh_cnt_reg <= '0;
      end else if (sample_now) begin
         // [R10] compare demag sample
         ovp_cnt_reg <= cyc_count(ovp_cnt_reg, cmp.demag_over);
         uvp_cnt_reg <= cyc_count(uvp_cnt_reg, cmp.demag_under && !uv_blank &&
                                  ctrl_reg[SPS_CTRL_UVP_EN]);
         // [R13] external high count
         exh_cnt_reg <= cyc_count(exh_cnt_reg, cmp.ext_above_high && ctrl_reg[SPS_CTRL_EXT_EN]);
      end
   end

   // [R14] value from 100ns before the falling edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_low_hist_reg <= '0;
         ext_low_smp_reg <= 1'b0;
      end else begin
         ext_low_hist_reg <= {ext_low_hist_reg[SPS_PRE_EDGE_CYC-1:0], cmp.ext_below_low};
         if (gate_fall) ext_low_smp_reg <= ext_low_hist_reg[SPS_PRE_EDGE_CYC];
      end
   end

   // [R15] 32ms low filter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_low_cnt_reg <= '0;
      end else if (pwr_reg != SPS_PWR_RUN || !ext_low_smp_reg || !ctrl_reg[SPS_CTRL_EXT_EN]) begin
         ext_low_cnt_reg <= '0;
      end else if (ext_low_cnt_reg < CW'(EXT_LOW_CYC)) begin
         ext_low_cnt_reg <= ext_low_cnt_reg + 1'b1;
      end
   end

   always_comb begin
      ev = '0;
      // [R11] seven consecutive cycles
      ev[SPS_EV_OVP] = ovp_cnt_reg == 3'(FAULT_CYCLES);
      ev[SPS_EV_UVP] = uvp_cnt_reg == 3'(FAULT_CYCLES);
      ev[SPS_EV_EXT_HI] = exh_cnt_reg == 3'(FAULT_CYCLES);
      ev[SPS_EV_EXT_LO] = ext_low_cnt_reg >= CW'(EXT_LOW_CYC);
      ev[SPS_EV_LINE_LOW] = line_ok_reg && low_cnt_reg >= CW'(LINE_LOW_CYC - 1);
      ev[SPS_EV_DISCH] = !xcap_disch_reg && xcap_cnt_reg >= CW'(LINE_DET_CYC - 1) &&
                         !cross_edge;
   end

   // [R16] any latched fault stops gate
   assign fault_trip = |ev[SPS_EV_EXT_LO:SPS_EV_OVP];

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_drive <= 1'b0;
         ext_source_en <= 1'b0;
      end else begin
         // [R8] [R9] [R16] gate gating
         gate_drive <= gate_request && line_ok_reg && pwr_reg == SPS_PWR_RUN && !fault_trip;
         // [R17] constant current source
         ext_source_en <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave, zero wait states
   logic rd_stat;
   assign rd_stat = psel && penable && !pwrite && paddr == SPS_ADDR_INT_STAT;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat_reg <= '0;
      end else begin
         // new events win over the read clear
         int_stat_reg <= (rd_stat ? '0 : int_stat_reg) | ev;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_mask_reg <= '0;
         ctrl_reg <= SPS_CTRL_RESET;
      end else if (psel && penable && pready && pwrite) begin
         if (paddr == SPS_ADDR_INT_MASK) begin
            int_mask_reg <= pwdata[SPS_EV_W-1:0];
         end else if (paddr == SPS_ADDR_CTRL) begin
            ctrl_reg <= pwdata[1:0];
         end
      end
   end

   logic addr_ok;
   assign addr_ok = paddr == SPS_ADDR_STATUS || paddr == SPS_ADDR_INT_STAT ||
                    paddr == SPS_ADDR_INT_MASK || paddr == SPS_ADDR_CTRL;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         prdata <= '0;
         if (psel && !penable && !pwrite) begin
            if (paddr == SPS_ADDR_STATUS) begin
               prdata <= {22'h0, charge_sel, pwr_reg, xcap_disch_reg, line_ok_reg,
                          gate_drive, after_fault_reg, cmp.supply_below_uvlo, cmp.supply_at_start};
            end else if (paddr == SPS_ADDR_INT_STAT) begin
               prdata <= {26'h0, int_stat_reg};
            end else if (paddr == SPS_ADDR_INT_MASK) begin
               prdata <= {26'h0, int_mask_reg};
            end else if (paddr == SPS_ADDR_CTRL) begin
               prdata <= {30'h0, ctrl_reg};
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_stat_reg & int_mask_reg);
      end
   end

endmodule

// file: sps_seq_monitor.sv
// sps_seq_monitor: concurrent checks on the sequencer ports.
// assumes binding into the sequencer with its interval counts.
`timescale 1ns/1ps
module sps_seq_monitor
   import sps_pkg::*;
#(
   parameter int unsigned LINE_DET_CYC = SPS_LINE_DET_CYC,
   parameter int unsigned DISCH_CYC = SPS_DISCH_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire sps_cmp_t cmp_in,
   input wire logic gate_request,
   input wire logic gate_drive,
   input wire sps_charge_t charge_sel,
   input wire logic discharge_sink_en,
   input wire logic ext_source_en,
   input wire logic irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////////
   // raw crossing, so quiet time runs ahead of the synchronised copy
   logic cross_q;
   int unsigned quiet_cnt;
   int unsigned sink_cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cross_q <= 1'b0;
         quiet_cnt <= 0;
         sink_cnt <= 0;
      end else begin
         cross_q <= cmp_in.line_cross;
         quiet_cnt <= (cmp_in.line_cross != cross_q) ? 0 : quiet_cnt + 1;
         sink_cnt <= discharge_sink_en ? sink_cnt + 1 : 0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_gate_needs_req: assert property (gate_drive |-> $past(gate_request))
      else $error("gate without request");
   a_gate_off_fault: assert property (charge_sel == SPS_CHG_FAULT |-> !gate_drive)
      else $error("gate on during fault charge");
   a_low_below_6v: assert property (!cmp_in.supply_above_6v [*5] |-> charge_sel != SPS_CHG_HIGH)
      else $error("high charge below 6V");
   a_charger_off_start: assert property ((cmp_in.supply_at_start && !cmp_in.supply_below_uvlo) [*5]
      |-> charge_sel == SPS_CHG_OFF)
      else $error("charger on at start");
   a_sink_after_quiet: assert property ($rose(discharge_sink_en) |-> quiet_cnt >= LINE_DET_CYC)
      else $error("discharge began early");
   a_sink_bounded: assert property (sink_cnt <= DISCH_CYC + 1)
      else $error("discharge phase too long");
   a_sink_stops_low: assert property (cmp_in.line_pin_below_10v [*5] |-> !discharge_sink_en)
      else $error("discharge below 10V");
   a_source_always: assert property ($past(presetn) |-> ext_source_en)
      else $error("control pin source off");
   a_ready_follows: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("ready not one pulse");
   a_err_unmapped: assert property (psel && !penable && paddr > 8'h0C |=> pslverr && prdata == 32'h0)
      else $error("unmapped not refused");
   c_sink: cover property ($rose(discharge_sink_en));
   c_fault_charge: cover property (charge_sel == SPS_CHG_FAULT);
   c_irq: cover property ($rose(irq));
endmodule

// file: sps_power_model.sv
// sps_power_model: line, supply and gate feedback comparators seen by the sequencer.
// assumes the bench sets static levels; crossings stop without line.
`timescale 1ns/1ps
module sps_power_model
   import sps_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic gate_drive,
   input wire logic ac_on,
   input wire sps_cmp_t levels,
   output sps_cmp_t cmp_in
);
   logic cross_reg;
   logic gate_reg;
   logic [5:0] phase_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cross_reg <= 1'b0;
         gate_reg <= 1'b0;
         phase_reg <= 6'h00;
      end else begin
         phase_reg <= phase_reg + 6'h01;
         gate_reg <= gate_drive;
         if (ac_on && phase_reg == 6'h3F) begin
            cross_reg <= !cross_reg;
         end
      end
   end
   always_comb begin
      cmp_in = levels;
      cmp_in.line_cross = cross_reg;
      cmp_in.gate_in = gate_reg;
   end
endmodule

// file: tb_top.sv
// tb_top: directed scenarios for the sequencer beside a power stage model.
// assumes shortened intervals, a few thousand cycles per scenario.
`timescale 1ns/1ps
module tb_top
   import sps_pkg::*;
;
   localparam int unsigned DET = 200;
   localparam int unsigned DIS = 200;
   localparam int unsigned LLOW = 300;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, gate_drive, discharge_sink_en, ext_source_en, irq;
   logic gate_request = 1'b0;
   sps_charge_t charge_sel;
   sps_cmp_t cmp_in;
   sps_cmp_t lv = '0;
   logic ac_on = 1'b1;
   logic pwm_on = 1'b0;
   int pwm_cnt = 0;
   int fail_count = 0;
   int checks = 0;
   logic [31:0] rd;
   logic err;

   always #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      pwm_cnt <= (!pwm_on || pwm_cnt == 599) ? 0 : pwm_cnt + 1;
      gate_request <= pwm_on && (pwm_cnt < 300);
   end

   sps_sequencer #(.LINE_DET_CYC(DET), .DISCH_CYC(DIS), .LINE_LOW_CYC(LLOW), .EXT_LOW_CYC(150),
      .UV_BLANK_CYC(100), .LINE_GOOD_CYC(50), .FAULT_CYCLES(7)) dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .cmp_in, .gate_request, .gate_drive, .charge_sel, .discharge_sink_en,
      .ext_source_en, .irq);
   sps_power_model stage (.pclk, .presetn, .gate_drive, .ac_on, .levels(lv), .cmp_in);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         $display("wrong value %s expected %0h seen %0h", name, exp, got);
         fail_count++;
      end
   endtask
   function automatic logic sig(input int i);
      case (i)
         0: return gate_drive;
         1: return discharge_sink_en;
         default: return irq;
      endcase
   endfunction
   task automatic await(input string name, input int i, input logic v, input int bound);
      int n = 0;
      while (sig(i) !== v && n < bound) begin
         @(posedge pclk);
         n++;
      end
      check(name, v, sig(i));
      if (sig(i) !== v) summarize();
   endtask
   task automatic do_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      pwm_on <= 1'b0;
      lv <= '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
   endtask
   // access held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      check("pready", 1, pready);
      if (pready !== 1'b1) summarize();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic run_up();
      lv.supply_above_6v <= 1'b1;
      lv.supply_at_start <= 1'b1;
      lv.line_above_good <= 1'b1;
      pwm_on <= 1'b1;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_setup();
      do_reset();
      apb(1'b0, SPS_ADDR_CTRL, 32'h0);
      check("ctrl reset", {30'h0, SPS_CTRL_RESET}, rd);
      apb(1'b1, SPS_ADDR_INT_MASK, 32'h3F);
      apb(1'b0, SPS_ADDR_INT_MASK, 32'h0);
      check("mask rw", 32'h3F, rd);
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped err", 1, err);
      check("charge low", SPS_CHG_LOW, charge_sel);
      lv.supply_above_6v <= 1'b1;
      repeat (6) @(posedge pclk);
      check("charge high", SPS_CHG_HIGH, charge_sel);
      lv.supply_at_start <= 1'b1;
      repeat (6) @(posedge pclk);
      check("charge off", SPS_CHG_OFF, charge_sel);
      $display("setup test done");
   endtask
   task automatic t_run();
      int n;
      do_reset();
      apb(1'b1, SPS_ADDR_INT_MASK, 32'h10);
      run_up();
      repeat (30) @(posedge pclk);
      check("gate early", 0, gate_drive);
      await("gate on", 0, 1'b1, 300);
      lv.line_above_good <= 1'b0;
      lv.line_below_low <= 1'b1;
      repeat (150) @(posedge pclk);
      check("gate kept", 1, gate_drive);
      repeat (LLOW) @(posedge pclk);
      n = 0;
      repeat (700) begin
         @(posedge pclk);
         n += gate_drive;
      end
      check("gate stopped", 0, n);
      await("irq up", 2, 1'b1, 5);
      apb(1'b0, SPS_ADDR_INT_STAT, 32'h0);
      check("line low event", 32'h10, rd);
      await("irq clear", 2, 1'b0, 5);
      lv.line_below_low <= 1'b0;
      lv.line_above_good <= 1'b1;
      await("gate back", 0, 1'b1, 1000);
      $display("run test done");
   endtask
   task automatic t_fault(input int k);
      int falls = 0;
      int quiet = 0;
      int n = 0;
      logic prev = 1'b0;
      do_reset();
      run_up();
      repeat (100) @(posedge pclk);
      await("gate rise", 0, 1'b1, 700);
      await("gate fall", 0, 1'b0, 700);
      repeat (250) @(posedge pclk);
      case (k)
         0: lv.demag_over <= 1'b1;
         1: lv.demag_under <= 1'b1;
         2: lv.ext_above_high <= 1'b1;
         default: lv.ext_below_low <= 1'b1;
      endcase
      while (quiet < 800 && n < 20000) begin
         @(posedge pclk);
         n++;
         quiet = (gate_drive === 1'b1) ? 0 : quiet + 1;
         if (prev === 1'b1 && gate_drive === 1'b0) falls++;
         prev = gate_drive;
      end
      if (k < 3) check("fault falls", 7, falls);
      else check("low filter", 1, falls >= 1 && falls <= 2);
      check("charger held off", SPS_CHG_OFF, charge_sel);
      apb(1'b0, SPS_ADDR_INT_STAT, 32'h0);
      check("fault event", 32'h1 << k, rd);
      lv.supply_at_start <= 1'b0;
      lv.supply_below_uvlo <= 1'b1;
      repeat (6) @(posedge pclk);
      check("fault charge", SPS_CHG_FAULT, charge_sel);
      check("gate held off", 0, gate_drive);
      $display("fault test %0d done", k);
   endtask
   task automatic t_disch();
      int n = 0;
      do_reset();
      repeat (3 * DET) @(posedge pclk);
      check("sink line on", 0, discharge_sink_en);
      err = cmp_in.line_cross;
      while (cmp_in.line_cross === err && n < 70) begin
         @(posedge pclk);
         n++;
      end
      check("crossing", 1, n < 70);
      n = 0;
      ac_on <= 1'b0;
      repeat (DET - 20) @(posedge pclk);
      check("sink early", 0, discharge_sink_en);
      await("sink on", 1, 1'b1, 100);
      while (discharge_sink_en === 1'b1 && n < 2 * DIS) begin
         @(posedge pclk);
         n++;
      end
      check("sink length", 1, n >= DIS - 2 && n <= DIS + 2);
      lv.supply_below_uvlo <= 1'b1;
      await("sink again", 1, 1'b1, DET + 100);
      lv.line_pin_below_10v <= 1'b1;
      await("sink stop", 1, 1'b0, DIS + 10);
      repeat (DET + DIS) @(posedge pclk);
      check("sink stays off", 0, discharge_sink_en);
      $display("discharge test done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      t_setup();
      t_run();
      for (int k = 0; k < 4; k++) t_fault(k);
      t_disch();
      summarize();
   end
endmodule

bind sps_sequencer sps_seq_monitor #(.LINE_DET_CYC(LINE_DET_CYC), .DISCH_CYC(DISCH_CYC)) u_mon (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .cmp_in, .gate_request, .gate_drive, .charge_sel, .discharge_sink_en,
   .ext_source_en, .irq);
